// ==== tb/cps_assertions.sv ====
module cps_assertions
  import cps_pkg::*;
#(
  parameter int unsigned SS_TIMEOUT = 200,
  parameter int unsigned SHUTDOWN = 100
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire sense_type sense,
  input wire logic clock_share_oe,
  input wire logic power_ok_in,
  input wire logic power_ok_oe,
  input wire pump_ctrl_type pump
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic on_q;
  logic [31:0] off_cnt;
  logic [31:0] ss_cnt;
  // Zero parks the count until a real enable fall
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      on_q <= 1'b0;
      off_cnt <= '0;
      ss_cnt <= '0;
    end else begin
      on_q <= sense.turn_on_input;
      if (on_q && !sense.turn_on_input) off_cnt <= 32'h1;
      else if (sense.turn_on_input) off_cnt <= '0;
      else if (off_cnt != '0 && off_cnt < SHUTDOWN + 2) off_cnt <= off_cnt + 32'h1;
      ss_cnt <= (pump.current_limit && !sense.output_rail_ok) ? ss_cnt + 32'h1 : '0;
    end
  end
  sequence line_low_s; !power_ok_in; endsequence
  sequence left_full_s; !pump.full_power; endsequence
  hold_start_a: assert property (off_cnt >= 1 && off_cnt <= SHUTDOWN + 1 |-> power_ok_oe)
    else $error("pull-down missing in shutdown hold");
  hold_end_a: assert property (off_cnt == SHUTDOWN + 2 |-> !power_ok_oe)
    else $error("disabled device still pulls line");
  lockout_stop_a: assert property (!sense.supply_above_lockout |=> !pump.switch_en)
    else $error("pump switching below lockout");
  pre_pull_a: assert property (pump.precharge |-> power_ok_oe)
    else $error("line released in pre-charge");
  early_rel_a: assert property (pump.current_limit && !power_ok_oe |-> $past(sense.output_rail_ok))
    else $error("line released before rail ok");
  rail_rel_a: assert property (pump.current_limit && sense.output_rail_ok && sense.turn_on_input
    && sense.supply_above_lockout |=> !power_ok_oe)
    else $error("line not released at rail ok");
  line_hold_a: assert property (line_low_s |=> left_full_s)
    else $error("full power with line low");
  full_entry_a: assert property ($rose(pump.full_power) |-> $past(power_ok_in) && $past(pump.current_limit))
    else $error("full power entered out of order");
  state_order_a: assert property ($rose(pump.current_limit) |-> $past(pump.precharge) || $past(pump.full_power))
    else $error("soft-start entered out of order");
  ss_bound_a: assert property (ss_cnt < SS_TIMEOUT + 2)
    else $error("soft-start outlived its timeout");
  clk_drive_a: assert property (clock_share_oe |=> clock_share_oe)
    else $error("clock pin drive changed after start");
endmodule

// ==== tb/far_side.sv ====
module far_side
  import cps_pkg::*;
(
  input wire logic core_clk,
  input wire logic on_cmd,
  input wire logic vin_ok,
  input wire logic pre_ok,
  input wire logic rail_up,
  input wire logic sib_pull,
  input wire logic ext_run,
  input wire logic sync_out,
  input wire logic sync_oe,
  input wire logic ok_out,
  input wire logic ok_oe,
  output sense_type sense,
  output logic ok_line,
  output logic sync_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] div = 7'h00;
  logic ext_clk = 1'b0;
  // One enable for every paralleled module; no load before the line is high
  assign sense = '{on_cmd, vin_ok, pre_ok, rail_up};
  // External pull-up unless a sibling or the device sinks it
  assign ok_line = (ok_oe ? ok_out : 1'b1) & ~sib_pull;
  // Sibling clock source, a little faster than ours
  always_ff @(posedge core_clk) begin
    div <= (div == 7'h59) ? 7'h00 : div + 7'h01;
    if (div == 7'h59) ext_clk <= ~ext_clk;
  end
  // Pin resistor to ground when nobody drives it
  assign sync_line = sync_oe ? sync_out : (ext_run & ext_clk);
endmodule

// ==== tb/testbench.sv ====
module testbench
  import cps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned ST = 200;
  localparam int unsigned SD = 100;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic strap = 1'b0;
  logic on = 1'b0, vin = 1'b0, pre = 1'b0, rail = 1'b0, sib = 1'b0, ext = 1'b0;
  axil_req_type req = '0;
  axil_rsp_type rsp;
  sense_type sense;
  pump_ctrl_type pump;
  logic ok_line, sync_line, s_out, s_oe, ok_out, ok_oe;
  logic [31:0] q;
  logic [1:0] r;
  int bad_count = 0, n_checks = 0, cycles = 0, i, k, e, f;
  charge_pump_startup_sequencer #(.SS_TIMEOUT(ST), .SHUTDOWN(SD)) DUT (.core_clk(core_clk), .arst_n(arst_n),
    .axil_req(req), .axil_rsp(rsp), .sense(sense), .clock_source_strap(strap), .clock_share_in(sync_line),
    .clock_share_out(s_out), .clock_share_oe(s_oe), .power_ok_in(ok_line), .power_ok_out(ok_out),
    .power_ok_oe(ok_oe), .pump(pump));
  far_side partner (.core_clk(core_clk), .on_cmd(on), .vin_ok(vin), .pre_ok(pre), .rail_up(rail),
    .sib_pull(sib), .ext_run(ext), .sync_out(s_out), .sync_oe(s_oe), .ok_out(ok_out), .ok_oe(ok_oe),
    .sense(sense), .ok_line(ok_line), .sync_line(sync_line));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Generous ceiling; the whole run needs about 5k cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Ready is read at the falling edge: combinational readies flip on the taking edge
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
    logic aw, w, ar, done;
    @(posedge core_clk);
    req <= '{a, we, d, 4'hF, we, we, a, ~we, ~we};
    do begin
      @(negedge core_clk);
      aw = rsp.awready;
      w = rsp.wready;
      ar = rsp.arready;
      done = we ? rsp.bvalid : rsp.rvalid;
      q = rsp.rdata;
      r = we ? rsp.bresp : rsp.rresp;
      @(posedge core_clk);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
      if (ar) req.arvalid <= 1'b0;
    end while (!done);
    req.bready <= 1'b0;
    req.rready <= 1'b0;
  endtask
  task automatic rst(input logic s);
    @(posedge core_clk);
    arst_n <= 1'b0;
    strap <= s;
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
  endtask
  task automatic wait_full;
    for (i = 0; i < 900 && !pump.full_power; i++) @(negedge core_clk);
  endtask
  // Window starts 90 cycles after a pin rise so pipeline lag cannot split a count
  task automatic t_rate;
    logic c, p;
    e = 0;
    f = 0;
    c = 1'b1;
    for (i = 0; i < 400 && !(sync_line && !c); i++) begin
      c = sync_line;
      @(negedge core_clk);
    end
    repeat (90) @(negedge core_clk);
    c = sync_line;
    p = pump.phase;
    repeat (800) begin
      @(negedge core_clk);
      e += int'(sync_line && !c);
      f += int'(pump.phase != p);
      c = sync_line;
      p = pump.phase;
    end
  endtask
  task automatic t_regs;
    bus(0, ADDR_CTRL, '0);
    chk({q[0], r}, {CTRL_RUN_RESET, RESP_OKAY});
    bus(0, ADDR_STATUS, '0);
    chk({q[8:0], r, s_oe}, {9'h041, RESP_OKAY, 1'b1});
    bus(0, 4'hC, '0);
    chk({q, r}, {32'h0, RESP_SLVERR});
    bus(1, ADDR_STATUS, 32'hFFFFFFFF);
    chk(32'(r), 32'(RESP_OKAY));
  endtask
  task automatic t_start;
    bus(1, ADDR_CTRL, '0);
    @(posedge core_clk);
    rail <= 1'b1;
    vin <= 1'b1;
    on <= 1'b1;
    repeat (20) @(negedge core_clk);
    chk(32'({pump.precharge, ok_oe}), 32'h0);
    bus(1, ADDR_CTRL, 32'h1);
    @(posedge core_clk);
    strap <= 1'b1;
    repeat (20) @(negedge core_clk);
    chk(32'({pump.precharge, pump.current_limit, ok_oe, s_oe}), 32'hB);
    @(posedge core_clk);
    pre <= 1'b1;
    rail <= 1'b0;
    for (i = 0; i < 50 && !pump.current_limit; i++) @(negedge core_clk);
    chk(32'({pump.switch_en, pump.current_limit, ok_oe}), 32'h7);
    @(posedge core_clk);
    rail <= 1'b1;
    wait_full();
    chk(32'({pump.full_power, pump.current_limit, ok_oe, ok_line}), 32'h9);
    bus(0, ADDR_STATUS, '0);
    chk(32'(q[8:0]), 32'h144);
    t_rate();
    chk(32'({e == 800 / (2 * SYNC_HALF_CYCLES), f == e}), 32'h3);
  endtask
  task automatic t_line;
    @(posedge core_clk);
    sib <= 1'b1;
    repeat (40) @(negedge core_clk);
    chk(32'({pump.full_power, pump.current_limit}), 32'h1);
    @(posedge core_clk);
    sib <= 1'b0;
    wait_full();
    chk(32'(pump.full_power), 32'h1);
  endtask
  task automatic t_shut;
    @(posedge core_clk);
    on <= 1'b0;
    for (i = 0; i < 5 && !ok_oe; i++) @(negedge core_clk);
    for (k = 0; k < SD + 20 && ok_oe; k++) @(negedge core_clk);
    chk(32'(k), SD + 1);
    chk(32'({pump.switch_en, ok_line}), 32'h1);
  endtask
  task automatic t_latch;
    @(posedge core_clk);
    rail <= 1'b0;
    on <= 1'b1;
    for (i = 0; i < 50 && !pump.current_limit; i++) @(negedge core_clk);
    for (k = 0; k < ST + 50 && pump.current_limit; k++) @(negedge core_clk);
    chk(32'(k >= ST && k <= ST + 1), 32'h1);
    @(posedge core_clk);
    rail <= 1'b1;
    repeat (30) @(negedge core_clk);
    bus(0, ADDR_COUNT, '0);
    chk({q[15:0], pump.switch_en}, {16'h0101, 1'b0});
    @(posedge core_clk);
    on <= 1'b0;
    repeat (5) @(posedge core_clk);
    on <= 1'b1;
    wait_full();
    chk(32'(pump.full_power), 32'h1);
    @(posedge core_clk);
    vin <= 1'b0;
    repeat (3) @(negedge core_clk);
    bus(0, ADDR_STATUS, '0);
    chk({q[2:0], pump.switch_en}, 4'h2);
    @(posedge core_clk);
    vin <= 1'b1;
  endtask
  task automatic t_ext;
    @(posedge core_clk);
    ext <= 1'b1;
    rst(1'b1);
    wait_full();
    t_rate();
    chk(32'({s_oe, f == e, e == 4}), 32'h3);
    bus(0, ADDR_STATUS, '0);
    chk(32'(q[4:3]), 32'h3);
    @(posedge core_clk);
    ext <= 1'b0;
    repeat (WD_CYCLES + 200) @(posedge core_clk);
    bus(0, ADDR_STATUS, '0);
    chk(32'(q[4:3]), 32'h1);
    t_rate();
    chk(32'(f >= 4 && f <= 5), 32'h1);
    @(posedge core_clk);
    ext <= 1'b1;
    repeat (400) @(posedge core_clk);
    bus(0, ADDR_STATUS, '0);
    chk(32'(q[4:3]), 32'h3);
  endtask
  initial begin
    rst(1'b0);
    t_regs();
    t_start();
    t_line();
    t_shut();
    t_latch();
    t_ext();
    end_of_test();
  end
endmodule
bind charge_pump_startup_sequencer cps_assertions #(.SS_TIMEOUT(SS_TIMEOUT), .SHUTDOWN(SHUTDOWN)) checker_i (
  .core_clk(core_clk), .arst_n(arst_n), .sense(sense), .clock_share_oe(clock_share_oe),
  .power_ok_in(power_ok_in), .power_ok_oe(power_ok_oe), .pump(pump));

// ==== verilog/charge_pump_startup_sequencer.sv ====
// Notes on behaviour
// - Straps captured once after reset, before switching.
// - Grounded clock strap: internal clock driven out.
// - Floating clock strap: share pin is clock input.
// - Missing external clock falls back, then returns.
// - Pump toggles at half the reference clock.
// - Turn-on input is active high, comparator hysteresis.
// - Supply below lockout stops pump switching.
// - Pre-charge runs until reported complete.
// - Soft-start current limited, ends at rail threshold.
// - Soft-start timeout latches off until enable toggles.
// - Release pull-down at threshold; external pull-up.
// - Line held low externally keeps soft-start.
// - Line pulled low at full power: soft-start.
// - Shared line; full power after all finish.
// - Disabled device does not pull line low.
// - Enable falling holds line low shutdown period.
// - Line released only at rail threshold or in full power.
// - Line state undefined below supply lockout.
// - Pre-biased rail still pulls line low.
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
module charge_pump_startup_sequencer
  import cps_pkg::*;
#(
  parameter int unsigned SS_TIMEOUT = SS_TIMEOUT_CYCLES,
  parameter int unsigned SHUTDOWN = SHUTDOWN_CYCLES
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire axil_req_type axil_req,
  output axil_rsp_type axil_rsp,
  input wire sense_type sense,
  input wire logic clock_source_strap,
  input wire logic clock_share_in,
  output logic clock_share_out,
  output logic clock_share_oe,
  input wire logic power_ok_in,
  output logic power_ok_out,
  output logic power_ok_oe,
  output pump_ctrl_type pump
);
  localparam logic [7:0] CNT_ONE = 8'h01;

  typedef struct packed {
    seq_state_type seq;
    logic strap_ext;
    logic en_prev;
    logic run_en;
    logic pull;
    pump_ctrl_type pump;
    logic [7:0] latch_count;
    logic [7:0] fallback_count;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } main_type;

  main_type main_reg;
  main_type main_next;

  logic en;
  logic active;
  logic ss_load;
  logic ss_clear;
  logic ss_expire;
  logic sd_load;
  logic sd_active;
  logic ref_tick;
  logic ext_active;
  logic rail_done;
  logic latch_event;
  logic fallback_event;
  logic count_clear;
  logic aw_take;
  logic w_take;
  logic have_aw;
  logic have_w;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] status_word;
  logic [31:0] count_word;

  clock_select u_clock_select (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .strap_valid(main_reg.seq != SEQ_STRAP),
    .ext_mode(main_reg.strap_ext),
    .clock_share_in(clock_share_in),
    .clock_share_out(clock_share_out),
    .clock_share_oe(clock_share_oe),
    .ref_tick(ref_tick),
    .ext_active(ext_active)
  );

  // Counts only while the rail is short of target
  down_timer #(
    .CYCLES(SS_TIMEOUT)
  ) u_ss_timer (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .load(ss_load),
    .clear(ss_clear),
    .pause(sense.output_rail_ok),
    .active(),
    .expire(ss_expire)
  );

  down_timer #(
    .CYCLES(SHUTDOWN)
  ) u_sd_timer (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .load(sd_load),
    .clear(en),
    .pause(1'b0),
    .active(sd_active),
    .expire()
  );

  always_comb begin
    main_next = main_reg;
    en = sense.turn_on_input && main_reg.run_en;
    active = en && sense.supply_above_lockout;
    rail_done = sense.output_rail_ok;
    latch_event = 1'b0;
    fallback_event = 1'b0;
    main_next.en_prev = en;
    sd_load = main_reg.en_prev && !en;

    unique case (main_reg.seq)
      SEQ_STRAP: begin
        // Taken once; strap moves later are ignored
        main_next.strap_ext = clock_source_strap;
        main_next.seq = SEQ_IDLE;
      end
      SEQ_IDLE: begin
        if (active) begin
          main_next.seq = SEQ_PRECHARGE;
        end
      end
      SEQ_PRECHARGE: begin
        if (!active) begin
          main_next.seq = SEQ_IDLE;
        end else if (sense.precharge_done) begin
          main_next.seq = SEQ_SOFT_START;
        end
      end
      SEQ_SOFT_START: begin
        if (!active) begin
          main_next.seq = SEQ_IDLE;
        end else if (ss_expire) begin
          main_next.seq = SEQ_LATCHED;
          latch_event = 1'b1;
        end else if (rail_done && power_ok_in) begin
          // Any other module still low keeps everyone here
          main_next.seq = SEQ_FULL_POWER;
        end
      end
      SEQ_FULL_POWER: begin
        if (!active) begin
          main_next.seq = SEQ_IDLE;
        end else if (!power_ok_in) begin
          main_next.seq = SEQ_SOFT_START;
          fallback_event = 1'b1;
        end
      end
      SEQ_LATCHED: begin
        // Only an enable low releases the latch
        if (!en) begin
          main_next.seq = SEQ_IDLE;
        end
      end
      default: begin
        main_next.seq = SEQ_IDLE;
      end
    endcase

    ss_load = main_next.seq == SEQ_SOFT_START && main_reg.seq != SEQ_SOFT_START;
    ss_clear = main_next.seq != SEQ_SOFT_START;

    // Pre-biased rail does not skip the pull-down
    // Below lockout the line is a don't-care, so pulling there is harmless
    main_next.pull = (en && !(main_next.seq == SEQ_FULL_POWER
      || (main_next.seq == SEQ_SOFT_START && rail_done)))
      || sd_load || sd_active;

    main_next.pump.switch_en = main_next.seq == SEQ_SOFT_START || main_next.seq == SEQ_FULL_POWER;
    main_next.pump.current_limit = main_next.seq == SEQ_SOFT_START;
    main_next.pump.precharge = main_next.seq == SEQ_PRECHARGE;
    main_next.pump.full_power = main_next.seq == SEQ_FULL_POWER;
    if (!main_next.pump.switch_en) begin
      main_next.pump.phase = 1'b0;
    end else if (ref_tick) begin
      main_next.pump.phase = !main_reg.pump.phase;
    end

    status_word = '0;
    status_word[ST_STATE_LSB +: 3] = main_reg.seq;
    status_word[ST_EXT_MODE_BIT] = main_reg.strap_ext;
    status_word[ST_EXT_ACTIVE_BIT] = ext_active;
    status_word[ST_PULL_BIT] = main_reg.pull;
    status_word[ST_LINE_BIT] = power_ok_in;
    status_word[ST_SHUTDOWN_BIT] = sd_active;
    status_word[ST_ENABLE_BIT] = en;
    count_word = '0;
    count_word[CNT_LATCH_LSB +: 8] = main_reg.latch_count;
    count_word[CNT_FALLBACK_LSB +: 8] = main_reg.fallback_count;

    // Write channel: address and data in either order
    aw_take = axil_req.awvalid && !main_reg.aw_held && !main_reg.bvalid;
    w_take = axil_req.wvalid && !main_reg.w_held && !main_reg.bvalid;
    have_aw = main_reg.aw_held || aw_take;
    have_w = main_reg.w_held || w_take;
    wr_addr = main_reg.aw_held ? main_reg.aw_addr : axil_req.awaddr;
    wr_data = main_reg.w_held ? main_reg.w_data : axil_req.wdata;
    wr_strb = main_reg.w_held ? main_reg.w_strb : axil_req.wstrb;
    count_clear = 1'b0;
    if (main_reg.bvalid && axil_req.bready) begin
      main_next.bvalid = 1'b0;
    end
    if (have_aw && have_w && !main_reg.bvalid) begin
      main_next.aw_held = 1'b0;
      main_next.w_held = 1'b0;
      main_next.bvalid = 1'b1;
      main_next.bresp = RESP_OKAY;
      if (wr_addr == ADDR_CTRL) begin
        if (wr_strb[0]) begin
          main_next.run_en = wr_data[CTRL_RUN_BIT];
        end
      end else if (wr_addr == ADDR_COUNT) begin
        count_clear = 1'b1;
      end else if (wr_addr != ADDR_STATUS) begin
        main_next.bresp = RESP_SLVERR;
      end
    end else begin
      if (aw_take) begin
        main_next.aw_held = 1'b1;
        main_next.aw_addr = axil_req.awaddr;
      end
      if (w_take) begin
        main_next.w_held = 1'b1;
        main_next.w_data = axil_req.wdata;
        main_next.w_strb = axil_req.wstrb;
      end
    end

    // An event in the clearing cycle still counts once
    if (count_clear) begin
      main_next.latch_count = latch_event ? CNT_ONE : '0;
      main_next.fallback_count = fallback_event ? CNT_ONE : '0;
    end else begin
      main_next.latch_count = main_reg.latch_count + (latch_event ? CNT_ONE : '0);
      main_next.fallback_count = main_reg.fallback_count + (fallback_event ? CNT_ONE : '0);
    end

    // Read channel: one outstanding read
    if (main_reg.rvalid && axil_req.rready) begin
      main_next.rvalid = 1'b0;
    end
    if (axil_req.arvalid && !main_reg.rvalid) begin
      main_next.rvalid = 1'b1;
      main_next.rresp = RESP_OKAY;
      unique case (axil_req.araddr)
        ADDR_CTRL: begin
          main_next.rdata = '0;
          main_next.rdata[CTRL_RUN_BIT] = main_reg.run_en;
        end
        ADDR_STATUS: begin
          main_next.rdata = status_word;
        end
        ADDR_COUNT: begin
          main_next.rdata = count_word;
        end
        default: begin
          main_next.rdata = '0;
          main_next.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      main_reg <= '0;
      main_reg.seq <= SEQ_STRAP;
      main_reg.run_en <= CTRL_RUN_RESET;
    end else begin
      main_reg <= main_next;
    end
  end

  // Open drain: only ever pulls low, pull-up is external
  assign power_ok_out = 1'b0;
  assign power_ok_oe = main_reg.pull;
  assign pump = main_reg.pump;

  assign axil_rsp.awready = !main_reg.aw_held && !main_reg.bvalid;
  assign axil_rsp.wready = !main_reg.w_held && !main_reg.bvalid;
  assign axil_rsp.bvalid = main_reg.bvalid;
  assign axil_rsp.bresp = main_reg.bresp;
  assign axil_rsp.arready = !main_reg.rvalid;
  assign axil_rsp.rvalid = main_reg.rvalid;
  assign axil_rsp.rdata = main_reg.rdata;
  assign axil_rsp.rresp = main_reg.rresp;
endmodule

// ==== verilog/clock_select.sv ====
module clock_select
  import cps_pkg::*;
#(
  parameter int unsigned HALF = SYNC_HALF_CYCLES,
  parameter int unsigned WD = WD_CYCLES
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic strap_valid,
  input wire logic ext_mode,
  input wire logic clock_share_in,
  output logic clock_share_out,
  output logic clock_share_oe,
  output logic ref_tick,
  output logic ext_active
);
  localparam int unsigned DW = $clog2(HALF + 1);
  localparam int unsigned WW = $clog2(WD + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(HALF - 1);
  localparam logic [DW-1:0] DIV_ONE = DW'(1);
  localparam logic [WW-1:0] WD_LAST = WW'(WD - 1);
  localparam logic [WW-1:0] WD_ONE = WW'(1);

  typedef struct packed {
    logic [DW-1:0] div;
    logic osc;
    logic in_prev;
    logic [WW-1:0] wd;
    logic missing;
  } clksel_type;

  clksel_type clk_reg;
  clksel_type clk_next;
  logic wrap;
  logic int_rise;
  logic ext_rise;

  always_comb begin
    clk_next = clk_reg;
    wrap = clk_reg.div == DIV_LAST;
    int_rise = wrap && !clk_reg.osc;
    ext_rise = clock_share_in && !clk_reg.in_prev;
    clk_next.in_prev = clock_share_in;
    if (wrap) begin
      clk_next.div = '0;
      clk_next.osc = !clk_reg.osc;
    end else begin
      clk_next.div = clk_reg.div + DIV_ONE;
    end
    // Fallback after silence, back to the external clock on its next edge
    if (ext_rise) begin
      clk_next.wd = '0;
      clk_next.missing = 1'b0;
    end else if (clk_reg.wd == WD_LAST) begin
      clk_next.missing = 1'b1;
    end else begin
      clk_next.wd = clk_reg.wd + WD_ONE;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_reg <= '0;
      clk_reg.missing <= 1'b1;
    end else begin
      clk_reg <= clk_next;
    end
  end

  assign clock_share_out = clk_reg.osc;
  assign clock_share_oe = strap_valid && !ext_mode;
  assign ext_active = ext_mode && !clk_reg.missing;
  assign ref_tick = ext_active ? ext_rise : int_rise;
endmodule

// ==== verilog/cps_pkg.sv ====
package cps_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  // Internal sync clock is twice the 270 kHz pump rate
  localparam int unsigned INT_SYNC_HZ = 540_000;
  localparam int unsigned SYNC_HALF_CYCLES = CLK_HZ / (2 * INT_SYNC_HZ);
  localparam int unsigned WD_PERIODS = 4;
  localparam int unsigned WD_CYCLES = WD_PERIODS * (CLK_HZ / INT_SYNC_HZ);
  localparam int unsigned SS_TIMEOUT_MS = 100;
  localparam int unsigned SS_TIMEOUT_CYCLES = (CLK_HZ / 1000) * SS_TIMEOUT_MS;
  localparam int unsigned SHUTDOWN_MS = 60;
  localparam int unsigned SHUTDOWN_CYCLES = (CLK_HZ / 1000) * SHUTDOWN_MS;

  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 4'h8;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam logic CTRL_RUN_RESET = 1'b1;
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_EXT_MODE_BIT = 3;
  localparam int unsigned ST_EXT_ACTIVE_BIT = 4;
  localparam int unsigned ST_PULL_BIT = 5;
  localparam int unsigned ST_LINE_BIT = 6;
  localparam int unsigned ST_SHUTDOWN_BIT = 7;
  localparam int unsigned ST_ENABLE_BIT = 8;
  localparam int unsigned CNT_LATCH_LSB = 0;
  localparam int unsigned CNT_FALLBACK_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEQ_STRAP,
    SEQ_IDLE,
    SEQ_PRECHARGE,
    SEQ_SOFT_START,
    SEQ_FULL_POWER,
    SEQ_LATCHED
  } seq_state_type;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } axil_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axil_rsp_type;

  typedef struct packed {
    logic turn_on_input;
    logic supply_above_lockout;
    logic precharge_done;
    logic output_rail_ok;
  } sense_type;

  typedef struct packed {
    logic switch_en;
    logic phase;
    logic current_limit;
    logic precharge;
    logic full_power;
  } pump_ctrl_type;
endpackage

// ==== verilog/down_timer.sv ====
module down_timer
  import cps_pkg::*;
#(
  parameter int unsigned CYCLES = 1,
  parameter int unsigned W = $clog2(CYCLES + 1)
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic clear,
  input wire logic pause,
  output logic active,
  output logic expire
);
  typedef struct packed {
    logic [W-1:0] count;
  } timer_type;

  localparam logic [W-1:0] LOAD_VALUE = W'(CYCLES);
  localparam logic [W-1:0] ONE = W'(1);

  timer_type timer_reg;
  timer_type timer_next;

  always_comb begin
    timer_next = timer_reg;
    if (clear) begin
      timer_next.count = '0;
    end else if (load) begin
      timer_next.count = LOAD_VALUE;
    end else if (!pause && timer_reg.count != '0) begin
      timer_next.count = timer_reg.count - ONE;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_reg <= '0;
    end else begin
      timer_reg <= timer_next;
    end
  end

  assign active = timer_reg.count != '0;
  // Independent of load and clear, so the caller may steer them from its next state
  assign expire = !pause && timer_reg.count == ONE;
endmodule
